// ===== rtl/slov_core.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "slov_defines.svh"

// How it works
// - Port 2 enable (bit 8) replaces port 2 frames' lookup destination with its field.
// - Port 1 enable (bit 4) replaces port 1 frames' lookup destination with its field.
// - Port 0 enable (bit 0) replaces port 0 frames' lookup destination with its field.
// - Lookup attributes (age, static, filter, priority) pass unchanged during override.
// - Only the destination changes; the result still goes to normal forwarding.
// - Port 1 field bits 6:5: 00 is port 0, 10 is port 2, rest reserved.
// - Port 0 field bits 2:1: 01 is port 1, 10 is port 2, rest reserved.
// - A command register write while no access is pending launches the described table access.
// - Read completion shows as pending clearing; then software fetches read data.
// - Command bit 5: one reads the table, zero writes it; resets to zero.
// - Command bit 4: one picks default VID table, zero the VLAN table.
// - Command bits 3:0 index VLAN 0-15 or port 0-2; other port indices read as zero and ignore writes.
module slov_core import slov_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SLOV_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLOV_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire slov_lookup_t lk_in,
  output slov_lookup_t lk_out,
  output logic lk_overridden,
  output logic vlan_busy
);
  slov_core_state_t s_ff, nxt_s;
  slov_wr_t wr;
  logic wr_en, wr_ok, rd_en, rd_ok, launch;
  logic [`SLOV_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [`SLOV_IDX_W-1:0] wr_idx, rd_idx;
  logic [3:0] cmd_idx;
  logic [`SLOV_ENTRY_W-1:0] wrd_lo;
  logic [2:0] dec_dest [`SLOV_PORTS];
  logic dec_hit [`SLOV_PORTS];
  logic ovr_hit;
  logic [2:0] ovr_dest, lk_dest_in;

  // ****************************************
  // Bus front end
  // ****************************************
  slov_axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .wr_en(wr_en),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic [31:0] slov_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wr_idx = wr.addr[`SLOV_AW-1:2];
  assign rd_idx = rd_addr[`SLOV_AW-1:2];
  assign cmd_idx = s_ff.cmd[`SLOV_CMD_IDX_HI:`SLOV_CMD_IDX_LO];
  assign wrd_lo = s_ff.wrd[`SLOV_ENTRY_W-1:0];
  assign lk_dest_in = lk_in.dest;
  assign wr_ok = (wr_idx >= `SLOV_IDX_OVR) && (wr_idx <= `SLOV_IDX_STS);
  assign rd_ok = (rd_idx >= `SLOV_IDX_OVR) && (rd_idx <= `SLOV_IDX_STS);
  assign launch = wr_en && (wr_idx == `SLOV_IDX_CMD) && (s_ff.st == SLOV_IDLE);

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_data = `SLOV_REG_RST;
    if (rd_idx == `SLOV_IDX_OVR) begin
      rd_data = s_ff.ovr;
    end else if (rd_idx == `SLOV_IDX_CMD) begin
      rd_data = s_ff.cmd;
    end else if (rd_idx == `SLOV_IDX_WRD) begin
      rd_data = s_ff.wrd;
    end else if (rd_idx == `SLOV_IDX_RDD) begin
      rd_data = s_ff.rdd;
    end else if (rd_idx == `SLOV_IDX_STS) begin
      rd_data[`SLOV_STS_PEND] = s_ff.pend;
    end
  end

  // ****************************************
  // Override decoders, one per ingress port
  // ****************************************
  slov_ovr_dec #(.MAP0(`SLOV_DEST_NONE), .MAP1(`SLOV_DEST_P1), .MAP2(`SLOV_DEST_P2),
                 .MAP3(`SLOV_DEST_NONE)) u_dec0 (
    .en(s_ff.ovr[`SLOV_OVR_EN0]),
    .code(s_ff.ovr[`SLOV_OVR_D0_HI:`SLOV_OVR_D0_LO]),
    .hit(dec_hit[0]),
    .dest(dec_dest[0])
  );
  slov_ovr_dec #(.MAP0(`SLOV_DEST_P0), .MAP1(`SLOV_DEST_NONE), .MAP2(`SLOV_DEST_P2),
                 .MAP3(`SLOV_DEST_NONE)) u_dec1 (
    .en(s_ff.ovr[`SLOV_OVR_EN1]),
    .code(s_ff.ovr[`SLOV_OVR_D1_HI:`SLOV_OVR_D1_LO]),
    .hit(dec_hit[1]),
    .dest(dec_dest[1])
  );
  slov_ovr_dec #(.MAP0(`SLOV_DEST_P0), .MAP1(`SLOV_DEST_P1), .MAP2(`SLOV_DEST_NONE),
                 .MAP3(`SLOV_DEST_NONE)) u_dec2 (
    .en(s_ff.ovr[`SLOV_OVR_EN2]),
    .code(s_ff.ovr[`SLOV_OVR_D2_HI:`SLOV_OVR_D2_LO]),
    .hit(dec_hit[2]),
    .dest(dec_dest[2])
  );

  always_comb begin
    ovr_hit = 1'h0;
    ovr_dest = `SLOV_DEST_NONE;
    if (lk_in.ingress == `SLOV_ING_P0) begin
      ovr_hit = dec_hit[0];
      ovr_dest = dec_dest[0];
    end else if (lk_in.ingress == `SLOV_ING_P1) begin
      ovr_hit = dec_hit[1];
      ovr_dest = dec_dest[1];
    end else if (lk_in.ingress == `SLOV_ING_P2) begin
      ovr_hit = dec_hit[2];
      ovr_dest = dec_dest[2];
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    // Lookup result goes on to forwarding; only the destination may change
    nxt_s.res.valid = lk_in.valid;
    nxt_s.res.ingress = lk_in.ingress;
    nxt_s.res.attr = lk_in.attr;
    nxt_s.res.dest = (lk_in.valid && ovr_hit) ? ovr_dest : lk_in.dest;
    nxt_s.ovr_applied = lk_in.valid && ovr_hit;
    if (wr_en) begin
      if (wr_idx == `SLOV_IDX_OVR) begin
        nxt_s.ovr = slov_merge(s_ff.ovr, wr.data, wr.strb) & `SLOV_OVR_MASK;
      end else if (wr_idx == `SLOV_IDX_CMD) begin
        nxt_s.cmd = slov_merge(s_ff.cmd, wr.data, wr.strb) & `SLOV_CMD_MASK;
      end else if (wr_idx == `SLOV_IDX_WRD) begin
        nxt_s.wrd = slov_merge(s_ff.wrd, wr.data, wr.strb) & `SLOV_DATA_MASK;
      end
    end
    unique case (s_ff.st)
      SLOV_IDLE: begin
        if (launch) begin
          nxt_s.pend = 1'h1;
          nxt_s.st = SLOV_RUN;
        end
      end
      SLOV_RUN: begin
        if (s_ff.cmd[`SLOV_CMD_RNW]) begin
          nxt_s.rdd = `SLOV_REG_RST;
          if (!s_ff.cmd[`SLOV_CMD_SEL]) begin
            nxt_s.rdd[`SLOV_ENTRY_W-1:0] = s_ff.vtab[cmd_idx];
          end else if (cmd_idx < `SLOV_PORTS_IDX) begin
            nxt_s.rdd[`SLOV_ENTRY_W-1:0] = s_ff.ptab[cmd_idx[1:0]];
          end
        end else if (!s_ff.cmd[`SLOV_CMD_SEL]) begin
          nxt_s.vtab[cmd_idx] = wrd_lo;
        end else if (cmd_idx < `SLOV_PORTS_IDX) begin
          nxt_s.ptab[cmd_idx[1:0]] = wrd_lo;
        end
        nxt_s.st = SLOV_FIN;
      end
      SLOV_FIN: begin
        // Read data was loaded one edge earlier
        nxt_s.pend = 1'h0;
        nxt_s.st = SLOV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.cmd <= `SLOV_REG_RST;
      s_ff.st <= SLOV_IDLE;
      s_ff.vtab <= {`SLOV_VLAN_DEPTH{`SLOV_VTAB_RST}};
      s_ff.ptab <= {`SLOV_PORTS{`SLOV_PVID_RST}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lk_out = s_ff.res;
  assign lk_overridden = s_ff.ovr_applied;
  assign vlan_busy = s_ff.pend;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_launch_pend;
    launch |=> s_ff.pend && (s_ff.st == SLOV_RUN);
  endproperty
  a_launch_pend: assert property (p_launch_pend) else $error("Command write did not set pending");

  property p_pend_len;
    $rose(s_ff.pend) |-> s_ff.pend ##1 s_ff.pend ##1 !s_ff.pend;
  endproperty
  a_pend_len: assert property (p_pend_len) else $error("Pending did not last exactly two cycles");

  property p_vlan_read;
    (s_ff.st == SLOV_RUN) && s_ff.cmd[`SLOV_CMD_RNW] && !s_ff.cmd[`SLOV_CMD_SEL]
      |=> s_ff.pend && (s_ff.rdd[`SLOV_ENTRY_W-1:0] == s_ff.vtab[$past(cmd_idx)]);
  endproperty
  a_vlan_read: assert property (p_vlan_read) else $error("VLAN read data wrong or pending gone");

  property p_vlan_write;
    (s_ff.st == SLOV_RUN) && !s_ff.cmd[`SLOV_CMD_RNW] && !s_ff.cmd[`SLOV_CMD_SEL]
      |=> s_ff.vtab[$past(cmd_idx)] == $past(wrd_lo);
  endproperty
  a_vlan_write: assert property (p_vlan_write) else $error("VLAN table write lost");

  property p_pvid_read;
    (s_ff.st == SLOV_RUN) && s_ff.cmd[`SLOV_CMD_RNW] && s_ff.cmd[`SLOV_CMD_SEL] && (cmd_idx < `SLOV_PORTS_IDX)
      |=> s_ff.rdd[`SLOV_ENTRY_W-1:0] == s_ff.ptab[$past(cmd_idx[1:0])];
  endproperty
  a_pvid_read: assert property (p_pvid_read) else $error("Default VID read wrong");

  property p_pvid_range;
    (s_ff.st == SLOV_RUN) && s_ff.cmd[`SLOV_CMD_RNW] && s_ff.cmd[`SLOV_CMD_SEL] && (cmd_idx >= `SLOV_PORTS_IDX)
      |=> s_ff.rdd == `SLOV_REG_RST;
  endproperty
  a_pvid_range: assert property (p_pvid_range) else $error("Out of range port read not zero");

  property p_ovr_p0;
    lk_in.valid && (lk_in.ingress == `SLOV_ING_P0) && s_ff.ovr[`SLOV_OVR_EN0]
      && (s_ff.ovr[`SLOV_OVR_D0_HI:`SLOV_OVR_D0_LO] == 2'h1) |=> lk_out.dest == `SLOV_DEST_P1;
  endproperty
  a_ovr_p0: assert property (p_ovr_p0) else $error("Port 0 override not applied");

  property p_ovr_p1;
    lk_in.valid && (lk_in.ingress == `SLOV_ING_P1) && s_ff.ovr[`SLOV_OVR_EN1]
      && (s_ff.ovr[`SLOV_OVR_D1_HI:`SLOV_OVR_D1_LO] == 2'h2) |=> lk_out.dest == `SLOV_DEST_P2;
  endproperty
  a_ovr_p1: assert property (p_ovr_p1) else $error("Port 1 override not applied");

  property p_ovr_p2;
    lk_in.valid && (lk_in.ingress == `SLOV_ING_P2) && s_ff.ovr[`SLOV_OVR_EN2]
      && (s_ff.ovr[`SLOV_OVR_D2_HI:`SLOV_OVR_D2_LO] == 2'h0) |=> lk_out.dest == `SLOV_DEST_P0;
  endproperty
  a_ovr_p2: assert property (p_ovr_p2) else $error("Port 2 override not applied");

  property p_attr_keep;
    lk_in.valid |=> lk_out.valid && (lk_out.attr == $past(lk_in.attr));
  endproperty
  a_attr_keep: assert property (p_attr_keep) else $error("Lookup attributes altered");

  property p_no_ovr;
    lk_in.valid && !ovr_hit |=> !lk_overridden && (lk_out.dest == $past(lk_dest_in));
  endproperty
  a_no_ovr: assert property (p_no_ovr) else $error("Destination changed without override");

  property p_pvid_write;
    (s_ff.st == SLOV_RUN) && !s_ff.cmd[`SLOV_CMD_RNW] && s_ff.cmd[`SLOV_CMD_SEL] && (cmd_idx < `SLOV_PORTS_IDX)
      |=> s_ff.ptab[$past(cmd_idx[1:0])] == $past(wrd_lo);
  endproperty
  a_pvid_write: assert property (p_pvid_write) else $error("Default VID table write lost");

  property p_pend_state;
    s_ff.pend == (s_ff.st != SLOV_IDLE);
  endproperty
  a_pend_state: assert property (p_pend_state) else $error("Pending out of step with table access");

  property p_rdd_settled;
    $fell(s_ff.pend) |-> $stable(s_ff.rdd);
  endproperty
  a_rdd_settled: assert property (p_rdd_settled) else $error("Read data changed as pending cleared");

  property p_ovr_res0;
    lk_in.valid && (lk_in.ingress == `SLOV_ING_P0) && s_ff.ovr[`SLOV_OVR_EN0]
      && (s_ff.ovr[`SLOV_OVR_D0_HI] == s_ff.ovr[`SLOV_OVR_D0_LO]) |=> !lk_overridden && (lk_out.dest == $past(lk_dest_in));
  endproperty
  a_ovr_res0: assert property (p_ovr_res0) else $error("Port 0 reserved code changed destination");

  property p_ovr_res1;
    lk_in.valid && (lk_in.ingress == `SLOV_ING_P1) && s_ff.ovr[`SLOV_OVR_EN1] && s_ff.ovr[`SLOV_OVR_D1_LO]
      |=> !lk_overridden && (lk_out.dest == $past(lk_dest_in));
  endproperty
  a_ovr_res1: assert property (p_ovr_res1) else $error("Port 1 reserved code changed destination");

  property p_lk_idle;
    !lk_in.valid |=> !lk_out.valid && !lk_overridden;
  endproperty
  a_lk_idle: assert property (p_lk_idle) else $error("Override flagged on an empty lookup slot");

  property p_cmd_keep;
    !(wr_en && (wr_idx == `SLOV_IDX_CMD)) |=> $stable(s_ff.cmd);
  endproperty
  a_cmd_keep: assert property (p_cmd_keep) else $error("Command register changed without a write");

  c_read_cmd: cover property (launch && wr.data[`SLOV_CMD_RNW] ##3 !s_ff.pend);
  c_write_cmd: cover property (launch && !wr.data[`SLOV_CMD_RNW] ##3 !s_ff.pend);
  c_override: cover property (lk_overridden);
  c_busy_write: cover property (s_ff.pend && wr_en && (wr_idx == `SLOV_IDX_CMD));
endmodule

`default_nettype wire

// ===== include/slov_defines.svh
`ifndef SLOV_DEFINES_SVH
`define SLOV_DEFINES_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define SLOV_AW 16
`define SLOV_IDX_W 14
`define SLOV_IDX_OVR 14'h180A
`define SLOV_IDX_CMD 14'h180B
`define SLOV_IDX_WRD 14'h180C
`define SLOV_IDX_RDD 14'h180D
`define SLOV_IDX_STS 14'h180E

// ****************************************
// Field positions and masks
// ****************************************
`define SLOV_OVR_EN0 0
`define SLOV_OVR_D0_LO 1
`define SLOV_OVR_D0_HI 2
`define SLOV_OVR_EN1 4
`define SLOV_OVR_D1_LO 5
`define SLOV_OVR_D1_HI 6
`define SLOV_OVR_EN2 8
`define SLOV_OVR_D2_LO 9
`define SLOV_OVR_D2_HI 10
`define SLOV_OVR_MASK 32'h000007F7
`define SLOV_CMD_RNW 5
`define SLOV_CMD_SEL 4
`define SLOV_CMD_IDX_HI 3
`define SLOV_CMD_IDX_LO 0
`define SLOV_CMD_MASK 32'h0000003F
`define SLOV_DATA_MASK 32'h0003FFFF
`define SLOV_STS_PEND 0

// ****************************************
// Reset values, sizes, encodings
// ****************************************
`define SLOV_REG_RST 32'h00000000
`define SLOV_VTAB_RST 18'h00000
`define SLOV_PVID_RST 18'h00001
`define SLOV_ENTRY_W 18
`define SLOV_VLAN_DEPTH 16
`define SLOV_PORTS 3
`define SLOV_PORTS_IDX 4'h3
`define SLOV_DEST_NONE 3'h0
`define SLOV_DEST_P0 3'h1
`define SLOV_DEST_P1 3'h2
`define SLOV_DEST_P2 3'h4
`define SLOV_ING_P0 2'h0
`define SLOV_ING_P1 2'h1
`define SLOV_ING_P2 2'h2
`define SLOV_RESP_OKAY 2'h0
`define SLOV_RESP_SLVERR 2'h2

`endif

// ===== include/slov_pkg.sv
`include "slov_defines.svh"

package slov_pkg;

  typedef struct packed {
    logic age_override;
    logic static_entry;
    logic age_filter;
    logic prio_en;
    logic [2:0] prio;
  } slov_attr_t;

  typedef struct packed {
    logic valid;
    logic [1:0] ingress;
    logic [2:0] dest;
    slov_attr_t attr;
  } slov_lookup_t;

  typedef struct packed {
    logic [`SLOV_AW-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } slov_wr_t;

  typedef enum logic [2:0] {
    SLOV_IDLE = 3'h1,
    SLOV_RUN = 3'h2,
    SLOV_FIN = 3'h4
  } slov_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    slov_wr_t wr;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slov_axil_state_t;

  typedef struct packed {
    logic [31:0] ovr;
    logic [31:0] cmd;
    logic [31:0] wrd;
    logic [31:0] rdd;
    logic pend;
    slov_state_t st;
    logic [`SLOV_VLAN_DEPTH-1:0][`SLOV_ENTRY_W-1:0] vtab;
    logic [`SLOV_PORTS-1:0][`SLOV_ENTRY_W-1:0] ptab;
    slov_lookup_t res;
    logic ovr_applied;
  } slov_core_state_t;

endpackage

// ===== rtl/slov_ovr_dec.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Override destination code to port mask
// ****************************************
module slov_ovr_dec #(
  parameter logic [2:0] MAP0 = 3'h0,
  parameter logic [2:0] MAP1 = 3'h0,
  parameter logic [2:0] MAP2 = 3'h0,
  parameter logic [2:0] MAP3 = 3'h0
) (
  input wire logic en,
  input wire logic [1:0] code,
  output logic hit,
  output logic [2:0] dest
);
  always_comb begin
    unique case (code)
      2'h0: dest = MAP0;
      2'h1: dest = MAP1;
      2'h2: dest = MAP2;
      2'h3: dest = MAP3;
    endcase
    // Reserved codes map to no port and leave the lookup result alone
    hit = en && (dest != 3'h0);
  end
endmodule

`default_nettype wire

// ===== rtl/slov_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "slov_defines.svh"

// ****************************************
// AXI4-Lite slave front end
// ****************************************
module slov_axil_slave import slov_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SLOV_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLOV_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output slov_wr_t wr,
  output logic wr_en,
  input wire logic wr_ok,
  output logic [`SLOV_AW-1:0] rd_addr,
  output logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  slov_axil_state_t s_ff, nxt_s;

  assign wr = s_ff.wr;
  assign wr_en = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
  assign rd_addr = s_axi_araddr;
  assign rd_en = s_axi_arvalid && s_ff.arready;
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;

  always_comb begin
    nxt_s = s_ff;
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'h1;
      nxt_s.awready = 1'h0;
      nxt_s.wr.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'h1;
      nxt_s.wready = 1'h0;
      nxt_s.wr.data = s_axi_wdata;
      nxt_s.wr.strb = s_axi_wstrb;
    end
    if (wr_en) begin
      nxt_s.aw_got = 1'h0;
      nxt_s.w_got = 1'h0;
      nxt_s.bvalid = 1'h1;
      nxt_s.bresp = wr_ok ? `SLOV_RESP_OKAY : `SLOV_RESP_SLVERR;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'h0;
      nxt_s.awready = 1'h1;
      nxt_s.wready = 1'h1;
    end
    if (rd_en) begin
      nxt_s.arready = 1'h0;
      nxt_s.rvalid = 1'h1;
      nxt_s.rdata = rd_ok ? rd_data : `SLOV_REG_RST;
      nxt_s.rresp = rd_ok ? `SLOV_RESP_OKAY : `SLOV_RESP_SLVERR;
    end
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'h0;
      nxt_s.arready = 1'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.awready <= 1'h1;
      s_ff.wready <= 1'h1;
      s_ff.arready <= 1'h1;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

`default_nettype wire

// ===== dv/tb_switch_lookup_override_vlan_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "slov_defines.svh"

module tb_switch_lookup_override_vlan_cmd import slov_pkg::*; ;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, lk_hit, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rs;
  slov_lookup_t lk_in = '0;
  slov_lookup_t lk_out;
  int failures = 0, check_count = 0, cycles = 0, busy_cycles = 0, b0;

  always #4 clk = ~clk;

  slov_core dut_u (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lk_in(lk_in), .lk_out(lk_out), .lk_overridden(lk_hit), .vlan_busy(busy));

  // ****************************************
  // Cycle watchdog and busy monitor
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1) begin
      busy_cycles++;
    end
    if (cycles == 8000) begin
      failures++;
      report_and_stop();
    end
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rdw(input logic [13:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp, input logic [1:0] er);
    rdw(idx);
    chk(rd, exp, "read data");
    chk({30'h0, rs}, {30'h0, er}, "read response");
  endtask

  task automatic poll();
    int n;
    n = 0;
    do begin
      rdw(`SLOV_IDX_STS);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk(rd, 32'h0, "pending clear");
  endtask

  task automatic lk(input logic [31:0] ov, input logic [1:0] ing, input logic [2:0] ed, input logic eh);
    wr(`SLOV_IDX_OVR, ov, 4'hF, `SLOV_RESP_OKAY);
    @(posedge clk);
    lk_in <= {1'b1, ing, 3'h3, 7'h5B};
    @(posedge clk);
    #1;
    chk({19'h0, lk_out}, {19'h0, 1'b1, ing, ed, 7'h5B}, "lookup result");
    chk({31'h0, lk_hit}, {31'h0, eh}, "override flag");
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(`SLOV_IDX_OVR, 32'h0, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_CMD, 32'h0, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_STS, 32'h0, `SLOV_RESP_OKAY);
    rchk(14'h1000, 32'h0, `SLOV_RESP_SLVERR);
    wr(14'h1000, 32'hFFFFFFFF, 4'hF, `SLOV_RESP_SLVERR);
    wr(`SLOV_IDX_OVR, 32'hFFFFFFFF, 4'hF, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_OVR, 32'h000007F7, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_OVR, 32'h0, 4'h2, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_OVR, 32'h000000F7, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_WRD, 32'hFFFFFFFF, 4'hF, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_WRD, 32'h0003FFFF, `SLOV_RESP_OKAY);
    lk(32'h3, 2'h0, 3'h2, 1'b1);
    lk(32'h5, 2'h0, 3'h4, 1'b1);
    lk(32'h1, 2'h0, 3'h3, 1'b0);
    lk(32'h7, 2'h0, 3'h3, 1'b0);
    lk(32'h4, 2'h0, 3'h3, 1'b0);
    lk(32'h3, 2'h1, 3'h3, 1'b0);
    lk(32'h10, 2'h1, 3'h1, 1'b1);
    lk(32'h50, 2'h1, 3'h4, 1'b1);
    lk(32'h30, 2'h1, 3'h3, 1'b0);
    lk(32'h100, 2'h2, 3'h1, 1'b1);
    lk(32'h300, 2'h2, 3'h2, 1'b1);
    wr(`SLOV_IDX_WRD, 32'h0002ABCD, 4'hF, `SLOV_RESP_OKAY);
    b0 = busy_cycles;
    wr(`SLOV_IDX_CMD, 32'h0F, 4'hF, `SLOV_RESP_OKAY);
    poll();
    chk(busy_cycles - b0, 32'h2, "busy cycles");
    wr(`SLOV_IDX_WRD, 32'h0, 4'hF, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_CMD, 32'h2F, 4'hF, `SLOV_RESP_OKAY);
    poll();
    rchk(`SLOV_IDX_RDD, 32'h0002ABCD, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_CMD, 32'h2F, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_CMD, 32'h32, 4'hF, `SLOV_RESP_OKAY);
    poll();
    rchk(`SLOV_IDX_RDD, 32'h1, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_CMD, 32'h33, 4'hF, `SLOV_RESP_OKAY);
    poll();
    rchk(`SLOV_IDX_RDD, 32'h0, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_WRD, 32'h00015555, 4'hF, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_CMD, 32'h10, 4'hF, `SLOV_RESP_OKAY);
    poll();
    wr(`SLOV_IDX_CMD, 32'h30, 4'hF, `SLOV_RESP_OKAY);
    poll();
    rchk(`SLOV_IDX_RDD, 32'h00015555, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_CMD, 32'h20, 4'hF, `SLOV_RESP_OKAY);
    poll();
    rchk(`SLOV_IDX_RDD, 32'h0, `SLOV_RESP_OKAY);
    wr(`SLOV_IDX_RDD, 32'hFFFF, 4'hF, `SLOV_RESP_OKAY);
    rchk(`SLOV_IDX_RDD, 32'h0, `SLOV_RESP_OKAY);
    report_and_stop();
  end

endmodule

`default_nettype wire
